// *** sbc_master.sv ***
`timescale 1ns/1ps
module sbc_master
  import sbc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Core request
  input  wire logic              req_valid,
  input  wire sbc_req_t          req,
  output logic                   req_ready,
  // Core response
  output sbc_resp_t              resp,
  // Bus pins driven by the master
  output logic                   bus_clk,
  output logic                   address_strobe_n,
  output logic                   upper_byte_strobe_n,
  output logic                   lower_byte_strobe_n,
  output logic                   rw_n,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  // Bus pins driven by the slave
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              transfer_ack_n,
  input  wire logic              bus_fault_n
);

  // Input synchronisers
  logic [SYNC_STAGES-1:0] ack_sync;
  logic [SYNC_STAGES-1:0] fault_sync;
  logic [DATA_W-1:0]      data_sync [DATA_STAGES];
  logic                   ack_seen;
  logic                   fault_seen;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_sync   <= '0;
      fault_sync <= '0;
    end else begin
      // Active high after inversion so reset means not asserted
      ack_sync   <= {ack_sync[SYNC_STAGES-2:0], ~transfer_ack_n};
      fault_sync <= {fault_sync[SYNC_STAGES-2:0], ~bus_fault_n};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_sync[0] <= DATA_RESET;
      data_sync[1] <= DATA_RESET;
    end else begin
      data_sync[0] <= data_in;
      data_sync[1] <= data_sync[0];
    end
  end

  assign ack_seen   = ack_sync[SYNC_STAGES-1];
  assign fault_seen = fault_sync[SYNC_STAGES-1];

  // Cycle state
  sbc_state_t state;
  sbc_state_t next_state;
  sbc_req_t   cur;
  sbc_req_t   next_cur;
  logic       acked;
  logic       next_acked;
  logic       faulted;
  logic       next_faulted;
  sbc_pins_t  pins;
  sbc_pins_t  next_pins;
  sbc_resp_t  next_resp;
  logic       next_req_ready;
  logic       term_now;

  assign term_now = ack_seen | fault_seen;

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_acked     = acked;
    next_faulted   = faulted;
    next_pins      = pins;
    next_resp      = resp;
    next_resp.done = 1'h0;

    unique case (state)
      ST_IDLE: begin
        // Start only when the next half period is high, so S0 is a high phase
        if (req_valid && req_ready && pins.bus_clk == BUS_CLK_LO) begin
          next_cur     = req;
          next_acked   = 1'h0;
          next_faulted = 1'h0;
          next_state   = ST_S0;
        end
      end
      ST_S0: begin
        next_state = ST_S1;
      end
      ST_S1: begin
        next_state = ST_S2;
      end
      ST_S2: begin
        next_state = ST_S3;
      end
      ST_S3: begin
        next_state = ST_S4;
      end
      ST_S4: begin
        // Recognition at the falling edge that ends S4
        if (term_now) begin
          next_acked   = ack_seen;
          next_faulted = fault_seen;
          next_state   = ST_S5;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Low half of a whole wait clock, then S4 again
        next_state = ST_S4;
      end
      ST_S5: begin
        next_state = ST_S6;
      end
      ST_S6: begin
        // Late fault is taken at the next falling edge after ack
        if (fault_seen) begin
          next_faulted = 1'h1;
        end
        next_state = ST_S7;
      end
      ST_S7: begin
        next_resp.done  = 1'h1;
        next_resp.fault = faulted;
        if (!cur.write && acked && !faulted) begin
          next_resp.rdata = data_sync[DATA_STAGES-1];
        end
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Pin values for the state being entered
    next_pins.bus_clk = sbc_clk_level(next_state);
    unique case (next_state)
      ST_IDLE: begin
        if (state == ST_S7) begin
          next_pins.addr_oe = 1'h0;
          next_pins.data_oe = 1'h0;
          next_pins.rw_n    = RW_READ;
        end
      end
      ST_S0: begin
        next_pins.rw_n = RW_READ;
      end
      ST_S1: begin
        next_pins.addr    = cur.addr;
        next_pins.addr_oe = 1'h1;
      end
      ST_S2: begin
        next_pins.address_strobe_n = 1'h0;
        if (cur.write) begin
          next_pins.rw_n = RW_WRITE;
        end else begin
          next_pins.upper_byte_strobe_n = ~cur.upper;
          next_pins.lower_byte_strobe_n = ~cur.lower;
        end
      end
      ST_S3: begin
        if (cur.write) begin
          next_pins.data    = cur.wdata;
          next_pins.data_oe = 1'h1;
        end
      end
      ST_S4: begin
        if (cur.write) begin
          next_pins.upper_byte_strobe_n = ~cur.upper;
          next_pins.lower_byte_strobe_n = ~cur.lower;
        end
      end
      ST_WAIT, ST_S5, ST_S6: begin
        // Strobes, address and data held unchanged
        next_pins.address_strobe_n = pins.address_strobe_n;
      end
      ST_S7: begin
        // Data and direction stay put on a write
        next_pins.address_strobe_n    = STROBE_IDLE;
        next_pins.upper_byte_strobe_n = STROBE_IDLE;
        next_pins.lower_byte_strobe_n = STROBE_IDLE;
      end
      default: begin
        next_pins = PINS_RESET;
      end
    endcase

    next_req_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= ST_IDLE;
      cur       <= '0;
      acked     <= 1'h0;
      faulted   <= 1'h0;
      pins      <= PINS_RESET;
      resp      <= RESP_RESET;
      req_ready <= 1'h0;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      acked     <= next_acked;
      faulted   <= next_faulted;
      pins      <= next_pins;
      resp      <= next_resp;
      req_ready <= next_req_ready;
    end
  end

  // Pin outputs are fields of the registered pin struct
  assign bus_clk             = pins.bus_clk;
  assign address_strobe_n    = pins.address_strobe_n;
  assign upper_byte_strobe_n = pins.upper_byte_strobe_n;
  assign lower_byte_strobe_n = pins.lower_byte_strobe_n;
  assign rw_n                = pins.rw_n;
  assign addr_out            = pins.addr;
  assign addr_oe             = pins.addr_oe;
  assign data_out            = pins.data;
  assign data_oe             = pins.data_oe;

endmodule // sbc_master

// *** sbc_master_assertions.sv ***
`timescale 1ns/1ps
module sbc_master_chk
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Pins and response
  input wire logic              address_strobe_n,
  input wire logic              upper_byte_strobe_n,
  input wire logic              lower_byte_strobe_n,
  input wire logic              rw_n,
  input wire logic              addr_oe,
  input wire logic              data_oe,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic              transfer_ack_n,
  input wire logic              bus_fault_n,
  input wire sbc_resp_t         resp
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  min_cycle_a: assert property (
    $fell(address_strobe_n) |-> !address_strobe_n [*5]) else $error("strobe too short");
  wait_hold_a: assert property (
    (!address_strobe_n && transfer_ack_n && bus_fault_n) [*3] |=> !address_strobe_n) else $error("no wait");
  write_order_a: assert property (
    $fell(address_strobe_n) && !rw_n |-> $past(rw_n) ##0 (upper_byte_strobe_n && lower_byte_strobe_n) [*2]
    ##1 !(upper_byte_strobe_n && lower_byte_strobe_n)) else $error("write order");
  strobe_neg_a: assert property (
    $rose(address_strobe_n) |-> upper_byte_strobe_n && lower_byte_strobe_n && rw_n == $past(rw_n, 2)
    && data_out == $past(data_out, 2) && data_oe == $past(data_oe, 2)) else $error("strobe negation");
  release_a: assert property (
    $rose(address_strobe_n) |=> !addr_oe && !data_oe && rw_n && resp.done) else $error("no release");
  rd_capture_a: assert property (
    $rose(address_strobe_n) && rw_n |=> resp.fault || resp.rdata == $past(data_in, 3)) else $error("rdata");
  sync_a: assert property (
    $rose(address_strobe_n) |-> !$past(transfer_ack_n, 4) || !$past(bus_fault_n, 4)) else $error("early end");
  fault_keep_a: assert property (
    resp.done && resp.fault |-> $stable(resp.rdata)) else $error("fault data");
endmodule // sbc_master_chk

bind sbc_master sbc_master_chk u_chk (.clk, .reset, .address_strobe_n, .upper_byte_strobe_n,
  .lower_byte_strobe_n, .rw_n, .addr_oe, .data_oe, .data_out, .data_in, .transfer_ack_n, .bus_fault_n, .resp);

// *** sbc_pkg.sv ***
package sbc_pkg;

  // Bus widths
  localparam int ADDR_W      = 23;
  localparam int DATA_W      = 16;

  // Depth of the acknowledge and fault synchroniser chains
  localparam int SYNC_STAGES = 3;
  // Depth of the read data input registers
  localparam int DATA_STAGES = 2;

  // Clock and bus timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int BUS_PERIOD_NS      = 20;
  localparam int HALF_STATE_CYCLES  = (BUS_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // Reset and idle values of the pins
  localparam logic            STROBE_IDLE = 1'h1;
  localparam logic            RW_READ     = 1'h1;
  localparam logic            RW_WRITE    = 1'h0;
  localparam logic            BUS_CLK_HI  = 1'h1;
  localparam logic            BUS_CLK_LO  = 1'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // Bus cycle states, one per half period of the bus clock
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_S0,
    ST_S1,
    ST_S2,
    ST_S3,
    ST_S4,
    ST_WAIT,
    ST_S5,
    ST_S6,
    ST_S7
  } sbc_state_t;

  // Request from the core side
  typedef struct packed {
    logic              write;
    logic              upper;
    logic              lower;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbc_req_t;

  // Pin outputs of the bus
  typedef struct packed {
    logic              bus_clk;
    logic              address_strobe_n;
    logic              upper_byte_strobe_n;
    logic              lower_byte_strobe_n;
    logic              rw_n;
    logic              addr_oe;
    logic [ADDR_W-1:0] addr;
    logic              data_oe;
    logic [DATA_W-1:0] data;
  } sbc_pins_t;

  // Completion reported to the core side
  typedef struct packed {
    logic              done;
    logic              fault;
    logic [DATA_W-1:0] rdata;
  } sbc_resp_t;

  localparam sbc_pins_t PINS_RESET = '{
    bus_clk:             BUS_CLK_LO,
    address_strobe_n:    STROBE_IDLE,
    upper_byte_strobe_n: STROBE_IDLE,
    lower_byte_strobe_n: STROBE_IDLE,
    rw_n:                RW_READ,
    addr_oe:             1'h0,
    addr:                ADDR_RESET,
    data_oe:             1'h0,
    data:                DATA_RESET
  };

  localparam sbc_resp_t RESP_RESET = '{
    done:  1'h0,
    fault: 1'h0,
    rdata: DATA_RESET
  };

  // Clock level driven during a state
  function automatic logic sbc_clk_level(input sbc_state_t st);
    unique case (st)
      ST_S0, ST_S2, ST_S4, ST_S6: sbc_clk_level = BUS_CLK_HI;
      default:                    sbc_clk_level = BUS_CLK_LO;
    endcase
  endfunction

endpackage

// *** sbc_slave.sv ***
`timescale 1ns/1ps
module sbc_slave
  import sbc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Answer control
  input  wire logic [4:0]        dly,
  input  wire logic [1:0]        mode,
  input  wire logic [DATA_W-1:0] rd_val,
  output logic [DATA_W-1:0]      wr_seen,
  // Bus
  input  wire logic              address_strobe_n,
  input  wire logic              upper_byte_strobe_n,
  input  wire logic              lower_byte_strobe_n,
  input  wire logic              rw_n,
  input  wire logic              addr_oe,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  output logic [DATA_W-1:0]      data_in,
  output logic                   transfer_ack_n,
  output logic                   bus_fault_n
);
  logic [4:0] cnt;
  logic       live;
  // Answer only until the strobes negate
  assign live = addr_oe && (!address_strobe_n || cnt < 5'h2);
  // Answer straight from the count, so a zero delay ack is already low at the edge entering S2
  assign transfer_ack_n = !(live && mode != 2'h1 && cnt >= dly);
  assign bus_fault_n    = !(live && mode != 2'h0 && cnt >= dly + (mode == 2'h2 ? 5'h2 : 5'h0));
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt            <= 5'h0;
      data_in        <= '0;
      wr_seen        <= '0;
    end else begin
      cnt            <= addr_oe ? cnt + 5'h1 : 5'h0;
      // Toggles once released
      data_in        <= (addr_oe && rw_n && !address_strobe_n) ? rd_val : ~data_in;
      if (data_oe && !rw_n && !(upper_byte_strobe_n && lower_byte_strobe_n)) wr_seen <= data_out;
    end
  end
endmodule // sbc_slave

// *** sync_bus_cycle_completion_tb.sv ***
`timescale 1ns/1ps
module sync_bus_cycle_completion_tb;
  import sbc_pkg::*;
  logic              clk, reset, req_valid, req_ready, bus_clk, rw_n, addr_oe, data_oe;
  logic              address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, transfer_ack_n, bus_fault_n;
  sbc_req_t          req;
  sbc_resp_t         resp;
  logic [DATA_W-1:0] data_out, data_in, rd_val, wr_seen;
  logic [4:0]        dly;
  logic [1:0]        mode;
  logic [ADDR_W-1:0] addr_out, addr_seen;
  logic [1:0]        be_sel, strb;
  int                err_total = 0, cmp_count = 0, ticks = 0, n, hi;

  sbc_master dut (.clk, .reset, .req_valid, .req, .req_ready, .resp, .bus_clk, .address_strobe_n,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .rw_n, .addr_out, .addr_oe, .data_out, .data_oe,
    .data_in, .transfer_ack_n, .bus_fault_n);
  sbc_slave slave (.clk, .reset, .dly, .mode, .rd_val, .wr_seen, .address_strobe_n, .upper_byte_strobe_n,
    .lower_byte_strobe_n, .rw_n, .addr_oe, .data_out, .data_oe, .data_in, .transfer_ack_n, .bus_fault_n);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One bus cycle; n counts clocks from the taking edge to done
  task automatic run(input logic w, input logic [15:0] d, input logic [4:0] dl, input logic [1:0] md);
    @(posedge clk);
    dly       <= dl;
    mode      <= md;
    rd_val    <= d;
    req       <= '{write: w, upper: be_sel[1], lower: be_sel[0], addr: 23'h2a5a5a, wdata: d};
    req_valid <= 1'h1;
    #1;
    while (!(req_ready === 1'h1 && bus_clk === 1'h0)) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    req_valid <= 1'h0;
    n    = 0;
    hi   = 0;
    strb = 2'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
      hi += bus_clk;
      strb |= {~upper_byte_strobe_n, ~lower_byte_strobe_n};
      if (!address_strobe_n) addr_seen = addr_out;
    end while (resp.done !== 1'h1 && n < 60);
  endtask

  task automatic t_read;
    run(1'h0, 16'h5ac3, 5'h0, 2'h0);
    check("read cycles", n, 8);
    check("read data", resp.rdata, 16'h5ac3);
    check("read strobes", strb, 2'h3);
    check("address", addr_seen, 23'h2a5a5a);
    check("clock highs", hi, 3);
    run(1'h0, 16'ha53c, 5'h0, 2'h0);
    check("next data", resp.rdata, 16'ha53c);
    check("no fault", resp.fault, 1'h0);
    $display("read test done");
  endtask

  task automatic t_write;
    run(1'h1, 16'hc35a, 5'h0, 2'h0);
    check("write cycles", n, 8);
    check("write data", wr_seen, 16'hc35a);
    check("rdata kept", resp.rdata, 16'ha53c);
    be_sel = 2'h1;
    run(1'h1, 16'h00a5, 5'h0, 2'h0);
    check("lower strobe", strb, 2'h1);
    check("lower write", wr_seen, 16'h00a5);
    be_sel = 2'h3;
    $display("write test done");
  endtask

  task automatic t_wait;
    for (int dl = 1; dl <= 4; dl++) begin
      run(1'h0, 16'h1234 + 16'(dl), 5'(dl), 2'h0);
      check("wait cycles", n, 8 + 2 * ((dl + 1) / 2));
      check("wait data", resp.rdata, 16'h1234 + dl);
    end
    $display("wait test done");
  endtask

  task automatic t_fault;
    run(1'h0, 16'h0ff0, 5'h0, 2'h1);
    check("fault flag", resp.fault, 1'h1);
    check("fault cycles", n, 8);
    check("fault data", resp.rdata, 16'h1238);
    run(1'h0, 16'h0f0f, 5'h0, 2'h2);
    check("late flag", resp.fault, 1'h1);
    check("late data", resp.rdata, 16'h1238);
    run(1'h0, 16'h3c3c, 5'h0, 2'h0);
    check("fault cleared", resp.fault, 1'h0);
    $display("fault test done");
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    forever begin
      @(posedge clk);
      ticks++;
      if (ticks == 2000) begin
        err_total++;
        complete_run();
      end
    end
  end

  initial begin
    reset     = 1'h1;
    req_valid = 1'h0;
    req       = '0;
    dly       = '0;
    mode      = '0;
    rd_val    = '0;
    be_sel    = 2'h3;
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    t_read();
    t_write();
    t_wait();
    t_fault();
    complete_run();
  end
endmodule // sync_bus_cycle_completion_tb
